// ---- rfp_pkg.sv ----
// constants, register map and types for the relay front-panel menu block
package rfp_pkg;
    localparam int unsigned CLK_HZ    = 40_000_000;
    localparam int unsigned MS_PER_S  = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    // press timing, in milliseconds
    localparam logic [12:0] DEBOUNCE_MS  = 13'h0014;  // 20 ms
    localparam logic [12:0] STEP_LONG_MS = 13'h01F4;  // 0.5 s
    localparam logic [12:0] SUB_MS       = 13'h03E8;  // 1 s
    localparam logic [12:0] SET_MS       = 13'h1388;  // 5 s
    localparam logic [12:0] DUR_MAX      = 13'h1FFF;
    localparam logic [7:0]  REPEAT_MS    = 8'hC8;     // 0.2 s scan rate
    localparam logic [15:0] DARK_MS      = 16'hEA60;  // 60 s idle to dark

    // menu geometry
    localparam logic [3:0] MENU_LAST = 4'hC;
    localparam logic [2:0] SUB_LAST  = 3'h4;
    localparam logic [3:0] TEST_LAST = 4'h8;
    localparam int unsigned NUM_TEST = 9;
    localparam int unsigned NUM_REC  = 11;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_BFT     = 8'h04;
    localparam logic [7:0] OFS_STAT    = 8'h08;
    localparam logic [7:0] OFS_TRAFFIC = 8'h0C;
    localparam logic [7:0] OFS_PASS    = 8'h10;
    localparam logic [7:0] OFS_SETTING = 8'h14;
    localparam logic [7:0] OFS_CMD     = 8'h18;
    localparam logic [7:0] OFS_REC     = 8'h40;
    localparam logic [7:0] OFS_REC_END = 8'h68;

    // control register fields and reset values
    localparam int unsigned CTRL_BAUD_BIT = 0;
    localparam int unsigned CTRL_BANK_BIT = 1;
    localparam int unsigned CTRL_CFG_LSB  = 4;
    localparam logic [7:0]  CTRL_RST      = 8'h71;  // 9.6 kBd, main bank, all inputs clear
    localparam logic [7:0]  BFT_RST       = 8'h14;  // 0.2 s in 10 ms units
    localparam logic [7:0]  BFT_MIN       = 8'h0A;
    localparam logic [7:0]  BFT_MAX       = 8'h64;
    localparam logic [15:0] SETTING_RST   = 16'h0000;

    typedef enum logic [1:0] {RFP_MAIN, RFP_SUB, RFP_TEST} rfp_view_t;

    typedef struct packed {
        logic prog;
        logic step;
    } rfp_btn_t;

    typedef struct packed {
        logic ext_remote_reset_input;
        logic two;
        logic one;
    } rfp_ext_t;
endpackage

// ---- rfp_menu.sv ----
// front-panel menu, setting edit, test mode and record clearing of the relay module
// Function
// - step press over 0.5 s moves one position forward
// - step press under 0.5 s moves one position backward
// - step held down keeps scanning forward at a fast repeat rate
// - dark display: 1 s step press goes to start, short press to end
// - program press of 1 s enters the submenu, acting on release
// - program held 5 s toggles setting mode
// - in setting mode each step press increments the digit at the cursor
// - in setting mode a 1 s program press moves the cursor on
// - in setting mode step and program together store the edited value
// - outside setting mode both buttons erase records and release latched relays
// - program alone releases latched relays only while the display is dark
// - records 1 to 11 cleared by buttons, serial command or external inputs
// - supply loss clears records; settings, rate and password are kept
// - from position 0 a test mode fires each start/operate signal in turn
// - data rate selectable 4.8 or 9.6 kBd, default 9.6 kBd
// - traffic counter reads zero while linked, else scrolls through 0 to 255
// - serial setting writes refused until the correct password is given
// - bank selector: 0 main settings, 1 second settings, default main
// - breaker-failure operate time is settable, default 0.2 s
// - a switchgroup decides which external inputs clear the records
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module rfp_menu #(
    parameter int unsigned  MS_CYCLES       = rfp_pkg::MS_CYCLES,
    parameter logic [15:0]  REMOTE_PASSWORD = 16'h0001   // arbitrary default
) (
    input  wire logic             clock,               // 40 MHz module clock
    input  wire logic             rst,                 // async reset, high
    input  wire logic [7:0]       wb_adr_i,            // wishbone byte address
    input  wire logic [31:0]      wb_dat_i,            // wishbone write data
    input  wire logic [3:0]       wb_sel_i,            // wishbone byte lanes
    input  wire logic             wb_we_i,             // wishbone write
    input  wire logic             wb_cyc_i,            // wishbone cycle
    input  wire logic             wb_stb_i,            // wishbone strobe
    output logic [31:0]           wb_dat_o,            // wishbone read data
    output logic                  wb_ack_o,            // wishbone ack
    input  wire rfp_pkg::rfp_btn_t btn_pin,            // push-buttons, high = pressed
    input  wire rfp_pkg::rfp_ext_t ext_pin,            // external control inputs
    input  wire logic             aux_supply_ok,       // auxiliary supply good
    input  wire logic             serial_clear_records_cmd, // clear pulse from link
    input  wire logic             comm_active,         // communicator linked
    input  wire logic             rec_wr,              // record write strobe
    input  wire logic [3:0]       rec_idx,             // record number 1..11
    input  wire logic [7:0]       rec_data,            // record value
    output logic                  disp_dark,           // display blanked
    output rfp_pkg::rfp_view_t    disp_view,           // main, submenu or test
    output logic [3:0]            disp_pos,            // main-menu position
    output logic [2:0]            disp_sub,            // submenu position
    output logic                  setting_mode,        // editing active
    output logic [1:0]            edit_cursor,         // digit under cursor
    output logic [15:0]           edit_value,          // bcd value being edited
    output logic [15:0]           setting_value,       // stored setting
    output logic [8:0]            test_sig,            // one-hot test signal
    output logic                  latch_release,       // pulse: free latched relays
    output logic                  records_cleared,     // pulse: records wiped
    output logic                  baud_9k6,            // 1 = 9.6 kBd, 0 = 4.8 kBd
    output logic                  bank_second,         // 1 = second settings
    output logic [7:0]            bf_time,             // breaker-failure time, 10 ms
    output logic [7:0]            traffic_count        // bus traffic counter
);
    import rfp_pkg::*;

    function automatic logic [15:0] inc_digit(input logic [15:0] v, input logic [1:0] c);
        logic [3:0]  d;
        logic [15:0] r;
        d = v[c*4 +: 4];
        r = v;
        r[c*4 +: 4] = (d >= 4'h9) ? 4'h0 : d + 4'h1;
        return r;
    endfunction

    // synchronisers
    rfp_btn_t btn_s1, btn_s2;
    rfp_ext_t ext_s1, ext_s2, ext_d;
    logic     aux_s1, aux_s2;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            btn_s1 <= '0;
            btn_s2 <= '0;
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_d  <= '0;
            aux_s1 <= 1'b1;
            aux_s2 <= 1'b1;
        end else begin
            btn_s1 <= btn_pin;
            btn_s2 <= btn_s1;
            ext_s1 <= ext_pin;
            ext_s2 <= ext_s1;
            ext_d  <= ext_s2;
            aux_s1 <= aux_supply_ok;
            aux_s2 <= aux_s1;
        end
    end

    // millisecond timebase
    logic [15:0] ms_cnt;
    logic        ms_tick;
    assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
    always_ff @(posedge clock or posedge rst) begin
        if (rst) ms_cnt <= '0;
        else     ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
    end

    // debounce and press duration, index 0 = step, 1 = program
    logic [1:0]       raw, deb, deb_d;
    logic [1:0][12:0] deb_cnt, dur;
    assign raw = {btn_s2.prog, btn_s2.step};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            deb     <= '0;
            deb_d   <= '0;
            deb_cnt <= '0;
            dur     <= '0;
        end else begin
            deb_d <= deb;
            for (int b = 0; b < 2; b++) begin
                if (raw[b] == deb[b]) deb_cnt[b] <= '0;
                else if (ms_tick) begin
                    if (deb_cnt[b] == DEBOUNCE_MS) begin
                        deb[b]     <= raw[b];
                        deb_cnt[b] <= '0;
                    end else deb_cnt[b] <= deb_cnt[b] + 13'h0001;
                end
                if (deb[b] && !deb_d[b]) dur[b] <= '0;
                else if (deb[b] && ms_tick && dur[b] != DUR_MAX) dur[b] <= dur[b] + 13'h0001;
            end
        end
    end

    // press classification
    logic       combo_reg, prog_held_reg, step_rep_reg;
    logic [7:0] rep_cnt;
    logic       step_rel, prog_rel, combo_done, prog_hold5, step_rep_evt;
    rfp_view_t  view_reg;
    logic       set_reg, dark_reg;
    assign step_rel     = deb_d[0] && !deb[0] && !combo_reg && !deb[1];
    assign prog_rel     = deb_d[1] && !deb[1] && !combo_reg && !deb[0];
    assign combo_done   = combo_reg && !deb[0] && !deb[1];
    assign prog_hold5   = deb[1] && !deb[0] && !combo_reg && ms_tick && dur[1] == SET_MS - 13'h0001;
    assign step_rep_evt = deb[0] && !deb[1] && !combo_reg && !set_reg && !dark_reg && ms_tick
                          && dur[0] >= SUB_MS && rep_cnt == 8'h00;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            combo_reg     <= 1'b0;
            prog_held_reg <= 1'b0;
            step_rep_reg  <= 1'b0;
            rep_cnt       <= '0;
        end else begin
            if (deb[0] && deb[1]) combo_reg <= 1'b1;
            else if (combo_done)  combo_reg <= 1'b0;
            if (deb[1] && !deb_d[1]) prog_held_reg <= 1'b0;
            else if (prog_hold5)     prog_held_reg <= 1'b1;
            if (deb[0] && !deb_d[0]) begin
                step_rep_reg <= 1'b0;
                rep_cnt      <= '0;
            end else if (step_rep_evt) begin
                step_rep_reg <= 1'b1;
                rep_cnt      <= REPEAT_MS - 8'h01;
            end else if (ms_tick && rep_cnt != 8'h00) rep_cnt <= rep_cnt - 8'h01;
        end
    end

    // display blanking after idle time
    logic [15:0] dark_cnt;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dark_cnt <= '0;
            dark_reg <= 1'b0;
        end else begin
            if (deb != deb_d) dark_cnt <= '0;
            else if (ms_tick && dark_cnt != DARK_MS) dark_cnt <= dark_cnt + 16'h0001;
            if (ms_tick && dark_cnt == DARK_MS - 16'h0001) dark_reg <= 1'b1;
            else if (deb_d != '0 && deb == '0) dark_reg <= 1'b0;
        end
    end

    // wishbone slave: data and ack one edge after the request, write on the ack edge
    logic        ack_reg, unlocked_reg, wr_ok, cmd_clear;
    logic [31:0] dat_reg;
    logic [7:0]  ctrl_reg, bft_reg;
    logic [7:0]  rec_mem [1:NUM_REC];
    logic [3:0]  rd_idx;
    assign wr_ok     = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i;
    assign cmd_clear = wr_ok && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[0];
    assign rd_idx    = 4'(((wb_adr_i - OFS_REC) >> 2) + 8'h01);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            dat_reg <= '0;
            if (wb_cyc_i && wb_stb_i && !ack_reg) begin
                unique case (wb_adr_i)
                    OFS_CTRL:    dat_reg <= {24'h000000, ctrl_reg};
                    OFS_BFT:     dat_reg <= {24'h000000, bft_reg};
                    OFS_STAT:    dat_reg <= {18'h00000, unlocked_reg, edit_cursor,
                                             disp_sub, dark_reg, set_reg, view_reg,
                                             disp_pos};
                    OFS_TRAFFIC: dat_reg <= {24'h000000, traffic_count};
                    OFS_SETTING: dat_reg <= {16'h0000, setting_value};
                    default: begin
                        if (wb_adr_i >= OFS_REC && wb_adr_i <= OFS_REC_END
                            && wb_adr_i[1:0] == 2'b00)
                            dat_reg <= {24'h000000, rec_mem[rd_idx]};
                    end
                endcase
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // password gate and link-side settings; kept across supply dips
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            unlocked_reg <= 1'b0;
            ctrl_reg     <= CTRL_RST;
            bft_reg      <= BFT_RST;
        end else if (wr_ok) begin
            if (wb_adr_i == OFS_PASS && wb_sel_i[1:0] == 2'b11)
                unlocked_reg <= (wb_dat_i[15:0] == REMOTE_PASSWORD);
            if (wb_adr_i == OFS_CTRL && wb_sel_i[0] && unlocked_reg)
                ctrl_reg <= {1'b0, wb_dat_i[6:4], 2'b00, wb_dat_i[1:0]};
            if (wb_adr_i == OFS_BFT && wb_sel_i[0] && unlocked_reg
                && wb_dat_i[7:0] >= BFT_MIN && wb_dat_i[7:0] <= BFT_MAX)
                bft_reg <= wb_dat_i[7:0];
        end
    end
    assign baud_9k6    = ctrl_reg[CTRL_BAUD_BIT];
    assign bank_second = ctrl_reg[CTRL_BANK_BIT];
    assign bf_time     = bft_reg;

    // menu, setting edit and test mode
    logic [3:0]  pos_reg, test_reg;
    logic [2:0]  sub_reg;
    logic [1:0]  cur_reg;
    logic [15:0] edit_reg, setting_reg;
    logic        fwd;
    assign fwd = dur[0] >= STEP_LONG_MS;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view_reg    <= RFP_MAIN;
            pos_reg     <= '0;
            sub_reg     <= '0;
            test_reg    <= '0;
            set_reg     <= 1'b0;
            cur_reg     <= '0;
            edit_reg    <= SETTING_RST;
            setting_reg <= SETTING_RST;
        end else begin
            if (wr_ok && wb_adr_i == OFS_SETTING && wb_sel_i[1:0] == 2'b11 && unlocked_reg)
                setting_reg <= wb_dat_i[15:0];
            if (step_rep_evt) begin
                unique case (view_reg)
                    RFP_MAIN: pos_reg <= (pos_reg == MENU_LAST) ? 4'h0 : pos_reg + 4'h1;
                    RFP_SUB:  sub_reg <= (sub_reg == SUB_LAST) ? 3'h0 : sub_reg + 3'h1;
                    RFP_TEST: test_reg <= (test_reg == TEST_LAST) ? 4'h0 : test_reg + 4'h1;
                endcase
            end else if (step_rel) begin
                if (set_reg) edit_reg <= inc_digit(edit_reg, cur_reg);
                else if (dark_reg) begin
                    view_reg <= RFP_MAIN;
                    if (dur[0] >= SUB_MS) pos_reg <= 4'h0;
                    else if (!fwd) pos_reg <= MENU_LAST;
                end else if (!step_rep_reg) begin
                    unique case (view_reg)
                        RFP_MAIN: pos_reg <= fwd ? ((pos_reg == MENU_LAST) ? 4'h0 : pos_reg + 4'h1)
                                                 : ((pos_reg == 4'h0) ? MENU_LAST : pos_reg - 4'h1);
                        RFP_SUB:  sub_reg <= fwd ? ((sub_reg == SUB_LAST) ? 3'h0 : sub_reg + 3'h1)
                                                 : ((sub_reg == 3'h0) ? SUB_LAST : sub_reg - 3'h1);
                        RFP_TEST: test_reg <= fwd ? ((test_reg == TEST_LAST) ? 4'h0 : test_reg + 4'h1)
                                                  : ((test_reg == 4'h0) ? TEST_LAST : test_reg - 4'h1);
                    endcase
                end
            end
            if (prog_hold5) begin
                set_reg  <= !set_reg;
                edit_reg <= setting_reg;
                cur_reg  <= 2'h0;
            end else if (prog_rel && !prog_held_reg && dur[1] >= SUB_MS && !dark_reg) begin
                if (set_reg) cur_reg <= cur_reg + 2'h1;
                else if (view_reg == RFP_MAIN) begin
                    view_reg <= (pos_reg == 4'h0) ? RFP_TEST : RFP_SUB;
                    sub_reg  <= 3'h0;
                    test_reg <= 4'h0;
                end else view_reg <= RFP_MAIN;
            end
            if (combo_done && set_reg) setting_reg <= edit_reg;
        end
    end
    assign disp_dark     = dark_reg;
    assign disp_view     = view_reg;
    assign disp_pos      = pos_reg;
    assign disp_sub      = sub_reg;
    assign setting_mode  = set_reg;
    assign edit_cursor   = cur_reg;
    assign edit_value    = edit_reg;
    assign setting_value = setting_reg;

    // test signal drive, latched-relay release and record clearing
    logic       latch_reg, clr_reg, clr_any;
    logic [8:0] test_q;
    rfp_ext_t   ext_rise;
    logic [2:0] ext_en;
    assign ext_rise = ext_s2 & ~ext_d;
    assign ext_en   = ctrl_reg[CTRL_CFG_LSB +: 3];
    assign clr_any  = (combo_done && !set_reg) || serial_clear_records_cmd || cmd_clear
                      || ((ext_rise & ext_en) != '0) || !aux_s2;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_reg <= 1'b0;
            clr_reg   <= 1'b0;
            test_q    <= '0;
            for (int i = 1; i <= NUM_REC; i++) rec_mem[i] <= '0;
        end else begin
            latch_reg <= (combo_done && !set_reg) || (prog_rel && dark_reg && dur[1] < SUB_MS);
            clr_reg   <= clr_any;
            test_q    <= (view_reg == RFP_TEST) ? 9'(9'h001 << test_reg) : 9'h000;
            if (clr_reg)
                for (int i = 1; i <= NUM_REC; i++) rec_mem[i] <= '0;
            else if (rec_wr && rec_idx >= 4'h1 && rec_idx <= 4'(NUM_REC))
                rec_mem[rec_idx] <= rec_data;
        end
    end
    assign latch_release   = latch_reg;
    assign records_cleared = clr_reg;
    assign test_sig        = test_q;

    // bus traffic counter
    logic [7:0] traf_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst)              traf_reg <= '0;
        else if (comm_active) traf_reg <= '0;
        else if (ms_tick)     traf_reg <= traf_reg + 8'h01;
    end
    assign traffic_count = traf_reg;

    // checks
    sequence s_step_fwd;
        step_rel && !set_reg && !dark_reg && !step_rep_reg && fwd && view_reg == RFP_MAIN
        && pos_reg < MENU_LAST && !step_rep_evt;
    endsequence
    sequence s_combo_clear;
        combo_done && !set_reg;
    endsequence
    property p_fwd;
        @(posedge clock) disable iff (rst) s_step_fwd |=> pos_reg == $past(pos_reg) + 4'h1;
    endproperty
    a_fwd: assert property (p_fwd) else $error("step long press did not advance");
    property p_back;
        @(posedge clock) disable iff (rst) step_rel && !set_reg && !dark_reg && !fwd
            && view_reg == RFP_MAIN && pos_reg > 4'h0 |=> pos_reg == $past(pos_reg) - 4'h1;
    endproperty
    a_back: assert property (p_back) else $error("step short press did not go back");
    property p_dark_start;
        @(posedge clock) disable iff (rst) step_rel && dark_reg && !set_reg
            && dur[0] >= SUB_MS |=> pos_reg == 4'h0 && !dark_reg;
    endproperty
    a_dark_start: assert property (p_dark_start) else $error("dark long step missed start");
    property p_toggle;
        @(posedge clock) disable iff (rst) prog_hold5 |=> set_reg != $past(set_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("setting mode did not toggle");
    property p_commit;
        @(posedge clock) disable iff (rst) combo_done && set_reg
            |=> setting_reg == $past(edit_reg);
    endproperty
    a_commit: assert property (p_commit) else $error("edited value not stored");
    property p_erase;
        @(posedge clock) disable iff (rst) s_combo_clear
            |=> latch_release && records_cleared ##1 rec_mem[1] == 8'h00;
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not clear records");
    property p_traffic;
        @(posedge clock) disable iff (rst) comm_active |=> traffic_count == 8'h00;
    endproperty
    a_traffic: assert property (p_traffic) else $error("traffic count not zero");
    property p_locked;
        @(posedge clock) disable iff (rst) wr_ok && !unlocked_reg && wb_adr_i == OFS_BFT
            |=> bf_time == $past(bf_time);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write changed setting");
    property p_test_onehot;
        @(posedge clock) disable iff (rst) view_reg == RFP_TEST ##1 view_reg == RFP_TEST
            |-> $onehot(test_sig) && test_sig[$past(test_reg)];
    endproperty
    a_test_onehot: assert property (p_test_onehot) else $error("test signal not one-hot");
endmodule

// ---- rfp_operator.sv ----
// operator model: presses the two front-panel buttons
`timescale 1ns/100ps
module rfp_operator #(
    parameter int unsigned MS_CYCLES = 4
) (
    input  wire logic         clock,  // module clock
    output rfp_pkg::rfp_btn_t btn     // high = pressed
);
    import rfp_pkg::*;
    initial btn = '0;
    // whole press, then a gap long enough for debounce to see the release
    task automatic press(input rfp_btn_t b, input int unsigned ms);
        @(posedge clock);
        btn <= b;
        repeat (ms * MS_CYCLES) @(posedge clock);
        btn <= '0;
        repeat (40 * MS_CYCLES) @(posedge clock);
    endtask
endmodule

// ---- tb.sv ----
// self-checking bench: register reads scored against a queue of expectations
`timescale 1ns/100ps
module tb;
    import rfp_pkg::*;
    localparam int unsigned MSC = 4;
    localparam logic [15:0] PW = 16'h0001;
    logic clock = 0, rst = 1, we = 0, cyc = 0, stb = 0, ack;
    logic [7:0] adr = 0, rec_data = 0, v;
    logic [31:0] wdat = 0, rdat;
    logic [3:0] rec_idx = 0;
    logic comm_active = 1, scmd = 0, rec_wr = 0;
    rfp_btn_t btn;
    rfp_ext_t ext = '0;
    logic [63:0] expq[$];
    int n_mismatch = 0, checks_done = 0, seed = 32'h84b2a878;
    always #12.5 clock = ~clock;
    rfp_operator #(.MS_CYCLES(MSC)) op_u (.clock(clock), .btn(btn));
    rfp_menu #(.MS_CYCLES(MSC), .REMOTE_PASSWORD(PW)) dut_u (.clock(clock), .rst(rst),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .btn_pin(btn), .ext_pin(ext),
        .aux_supply_ok(1'b1), .serial_clear_records_cmd(scmd), .comm_active(comm_active),
        .rec_wr(rec_wr), .rec_idx(rec_idx), .rec_data(rec_data), .disp_dark(),
        .disp_view(), .disp_pos(), .disp_sub(), .setting_mode(), .edit_cursor(),
        .edit_value(), .setting_value(), .test_sig(), .latch_release(),
        .records_cleared(), .baud_9k6(), .bank_second(), .bf_time(), .traffic_count());
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [63:0] e);
        checks_done++;
        if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
            n_mismatch++;
            $display("FAIL %0t read %h expected %h", $time, got, e[31:0] & e[63:32]);
        end
    endtask
    // one classic cycle; reads leave their expectation in the queue
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hFFFFFFFF);
        int n;
        n = 0;
        if (!w) expq.push_back({m, d});
        @(posedge clock);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("FAIL %0t no ack from slave", $time);
        end
        cyc <= 0; stb <= 0;
    endtask
    always @(posedge clock) begin
        if (ack === 1'b1 && !we && expq.size() > 0)
            chk(rdat, expq.pop_front());
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 0;
        wb(0, OFS_CTRL, {24'h0, CTRL_RST}, 32'h3);
        wb(0, OFS_BFT, {24'h0, BFT_RST});
        wb(0, 8'h30, 32'h0);
        v = BFT_MIN + 8'($unsigned($random(seed)) % 91);
        wb(1, OFS_BFT, {24'h0, v});
        wb(0, OFS_BFT, {24'h0, BFT_RST});
        wb(1, OFS_PASS, {16'h0, PW});
        wb(1, OFS_BFT, {24'h0, v});
        wb(0, OFS_BFT, {24'h0, v});
        @(posedge clock);
        rec_wr <= 1; rec_idx <= 4'h1; rec_data <= v;
        @(posedge clock);
        rec_wr <= 0; scmd <= 1;
        @(posedge clock);
        scmd <= 0;
        repeat (3) @(posedge clock);
        wb(0, OFS_REC, 32'h0);
        @(posedge clock);
        rec_wr <= 1; rec_idx <= 4'h1; rec_data <= v;
        @(posedge clock);
        rec_wr <= 0;
        @(posedge clock);
        wb(0, OFS_REC, {24'h0, v});
        @(posedge clock);
        ext <= 3'h1;
        repeat (3) @(posedge clock);
        ext <= 3'h0;
        repeat (6) @(posedge clock);
        wb(0, OFS_REC, 32'h0);
        wb(0, OFS_TRAFFIC, 32'h0);
        op_u.press(2'b01, 600);
        wb(0, OFS_STAT, 32'h1, 32'h3F);
        op_u.press(2'b01, 200);
        wb(0, OFS_STAT, 32'h0, 32'h3F);
        op_u.press(2'b01, 200);
        wb(0, OFS_STAT, {28'h0, MENU_LAST}, 32'h3F);
        op_u.press(2'b01, 1500);
        wb(0, OFS_STAT, 32'h2, 32'h3F);
        op_u.press(2'b10, 5200);
        wb(0, OFS_STAT, 32'h40, 32'h40);
        finish_test();
    end
endmodule
